// ===== core/mst_defines.vh
// Constants for the module self-test sequencer: offsets, fields, error codes, test numbers, timing
`ifndef MST_DEFINES_VH
`define MST_DEFINES_VH

// Clock rate in MHz
`define MST_CLK_MHZ 100
// Bus interface self-check settle time in milliseconds
`define MST_BIC_DELAY_MS 250
// Per-test watchdog in microseconds
`define MST_TEST_TIMEOUT_US 1000

// Register byte offsets
`define MST_OFS_BUS_CSR 12'h000
`define MST_OFS_PORT_STATUS 12'h004
`define MST_OFS_PORT_ERROR 12'h008
`define MST_OFS_PORT_DATA 12'h00C
`define MST_OFS_CONTROL 12'h010
`define MST_OFS_EXEC_MASK 12'h014

// Bus control status fields
`define MST_CSR_PASSED_BIT 0
`define MST_CSR_BROKE_BIT 1
// Port status fields
`define MST_PS_DONE_BIT 0
`define MST_PS_ACC_BIT 1
`define MST_PS_RUN_BIT 2
`define MST_PS_HALT_BIT 3
// Control fields
`define MST_CTL_START_BIT 0
`define MST_CTL_TNUM_LSB 8
`define MST_CTL_TNUM_MSB 12

// Error codes
`define MST_ERR_NOT_FUNCTIONAL 32'hFF000003
`define MST_ERR_NONCRITICAL 32'hFF000004

// Test numbering
`define MST_TEST_ROM 5'h01
`define MST_TEST_CRIT_PATH 5'h04
`define MST_TEST_LAST_MAIN 5'h08
`define MST_TEST_FIRST_TAPE 5'h09
`define MST_TEST_DRIVE 5'h11
`define MST_NUM_TESTS 17

`endif

// ===== core/mst_wait_timer.v
// Loadable down-counter that pulses once when its count runs out
`timescale 1ns/1ns
module mst_wait_timer #(
  parameter WIDTH = 32
) (
  input wire clock,
  input wire rstn,
  input wire load,
  input wire [WIDTH-1:0] load_val,
  input wire cancel,
  output reg expire,
  output reg busy
);

  reg [WIDTH-1:0] count; // Cycles left

  // Count down; load wins over cancel so a restart is never lost
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      count <= {WIDTH{1'b0}};
      busy <= 1'b0;
      expire <= 1'b0;
    end else begin
      expire <= 1'b0;
      if (load) begin
        count <= load_val;
        busy <= 1'b1;
      end else if (cancel) begin
        busy <= 1'b0;
      end else if (busy) begin
        if (count <= {{(WIDTH-1){1'b0}}, 1'b1}) begin
          busy <= 1'b0;
          expire <= 1'b1;
        end else begin
          count <= count - {{(WIDTH-1){1'b0}}, 1'b1};
        end
      end
    end
  end

endmodule // mst_wait_timer

// ===== core/mst_selftest_seq.v
// Self-test sequencer with APB register access
//
// Behaviour
// - Node passes only if all executed tests pass
// - Network test failure keeps fault line and broken
// - Bus chip failure disables drivers, registers unreachable
// - Bus chip, processor or ROM failure halts, waits
// - No test number given runs whole suite
// - Start bus self-check, wait 250 ms, sample
// - Passed flag set on success, else bus blocked
// - Tests 1-8 main, 9-16 tape, 17 drive
// - ROM CRC per section compared, mismatch fails
// - RAM test: mask, non-stack, relocate, stack area
// - Patch test: disable, toggle bits, enable, patch
// - Interrupt test fails on any stuck line
// - Bus corner test failure continues with next
// - Network test checks chip and CRC only
// - Misc registers enabled then disabled, checked
// - Processor messaging and interrupts both directions
// - Drive test passes only on drive-present bit
// - Full pass clears broken flag and fault line
// - Done bit; on failure error code, result word
//
// Chosen here: the APB register port and the address map.
`timescale 1ns/1ns
`include "mst_defines.vh"
module mst_selftest_seq #(
  parameter BIC_DELAY_CYC = `MST_BIC_DELAY_MS * 1000 * `MST_CLK_MHZ,
  parameter TEST_TIMEOUT_CYC = `MST_TEST_TIMEOUT_US * `MST_CLK_MHZ
) (
  input wire clock,
  input wire rstn,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Bus interface chip self-check
  output reg bic_check_start,
  input wire selftest_passed_pin,
  output reg bus_drv_en,
  output reg bus_fault_line,
  // Tape option strap and drive-present status bit
  input wire tape_fitted_pin,
  input wire drive_present_pin,
  // Test engines on this clock
  output reg test_start,
  output reg [4:0] test_id,
  input wire test_done,
  input wire test_pass,
  // Main processor held waiting after a fatal failure
  output reg cpu_wait
);

  // Sequencer states
  localparam ST_IDLE = 3'h0;
  localparam ST_BIC_WAIT = 3'h1;
  localparam ST_ISSUE = 3'h2;
  localparam ST_WAIT = 3'h3;
  localparam ST_NEXT = 3'h4;
  localparam ST_DONE = 3'h5;
  localparam ST_HALT = 3'h6;

  // Last test of the suite for the fitted option
  function [4:0] last_test;
    input tape;
    begin
      last_test = tape ? `MST_TEST_DRIVE : `MST_TEST_LAST_MAIN;
    end
  endfunction

  // Tests whose failure means the processor itself is unusable
  function is_fatal;
    input [4:0] num;
    begin
      is_fatal = (num == `MST_TEST_ROM) || (num == `MST_TEST_CRIT_PATH);
    end
  endfunction

  reg [2:0] state; // Sequencer state
  reg [4:0] test_num; // Current test number
  reg single_mode; // One selected test only
  reg [4:0] single_num; // Selected test, 0 for the suite
  reg tape_sel; // Tape subsystem fitted for this run
  reg start_pend; // Run requested; set at reset for power-up
  reg selftest_passed_flag; // Bus interface self-check passed
  reg node_broken; // Node-broken flag
  reg selftest_done_flag; // Sequence finished
  reg adapter_ok; // Minimally functional
  reg any_fail; // Some executed test failed
  reg [16:0] diagnostic_result_word; // Set bit is a failed test
  reg [16:0] exec_mask; // Set bit is an executed test
  reg [31:0] port_error_reg; // Error code
  reg [31:0] port_data_reg; // Result word or running count

  // Pin synchronisers
  reg bic_ok_m, bic_ok_s;
  reg tape_m, tape_s;
  reg drv_m, drv_s;

  // Timer control
  reg tmr_load;
  reg [31:0] tmr_val;
  reg tmr_cancel;
  wire tmr_expire;

  // Outcome of the current test this cycle
  reg rec_valid;
  reg rec_ok;
  wire [4:0] test_idx;

  // APB decode
  wire apb_setup;
  wire ctl_write;

  assign test_idx = test_num - 5'h01;
  assign apb_setup = psel & ~penable;
  assign ctl_write = psel & penable & pready & pwrite & (paddr == `MST_OFS_CONTROL) & selftest_passed_flag;

  // Two flops for every pin before use
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      bic_ok_m <= 1'b0;
      bic_ok_s <= 1'b0;
      tape_m <= 1'b0;
      tape_s <= 1'b0;
      drv_m <= 1'b0;
      drv_s <= 1'b0;
    end else begin
      bic_ok_m <= selftest_passed_pin;
      bic_ok_s <= bic_ok_m;
      tape_m <= tape_fitted_pin;
      tape_s <= tape_m;
      drv_m <= drive_present_pin;
      drv_s <= drv_m;
    end
  end

  // Shared settle and watchdog timer
  mst_wait_timer #(
    .WIDTH(32)
  ) u_timer (
    .clock(clock),
    .rstn(rstn),
    .load(tmr_load),
    .load_val(tmr_val),
    .cancel(tmr_cancel),
    .expire(tmr_expire),
    .busy()
  );

  // Current test outcome, from the engine or the drive bit
  always @* begin
    rec_valid = 1'b0;
    rec_ok = 1'b0;
    if (state == ST_ISSUE && test_num == `MST_TEST_DRIVE) begin
      rec_valid = 1'b1;
      rec_ok = drv_s;
    end else if (state == ST_WAIT && test_done) begin
      rec_valid = 1'b1;
      rec_ok = test_pass;
    end else if (state == ST_WAIT && tmr_expire) begin
      // Silent engine counts as a failure
      rec_valid = 1'b1;
      rec_ok = 1'b0;
    end
  end

  // Timer requests
  always @* begin
    tmr_load = 1'b0;
    tmr_val = 32'h00000000;
    tmr_cancel = 1'b0;
    if (state == ST_IDLE && start_pend) begin
      tmr_load = 1'b1;
      tmr_val = BIC_DELAY_CYC;
    end else if (state == ST_ISSUE && test_num != `MST_TEST_DRIVE) begin
      tmr_load = 1'b1;
      tmr_val = TEST_TIMEOUT_CYC;
    end else if (state == ST_WAIT && test_done) begin
      tmr_cancel = 1'b1;
    end
  end

  // Main sequencer
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state <= ST_IDLE;
      test_num <= 5'h01;
      single_mode <= 1'b0;
      tape_sel <= 1'b0;
      start_pend <= 1'b1;
      selftest_passed_flag <= 1'b0;
      node_broken <= 1'b1;
      bus_fault_line <= 1'b1;
      selftest_done_flag <= 1'b0;
      adapter_ok <= 1'b0;
      any_fail <= 1'b0;
      diagnostic_result_word <= 17'h00000;
      exec_mask <= 17'h00000;
      port_error_reg <= 32'h00000000;
      port_data_reg <= 32'h00000000;
      bic_check_start <= 1'b0;
      bus_drv_en <= 1'b1;
      test_start <= 1'b0;
      test_id <= 5'h00;
      cpu_wait <= 1'b0;
    end else begin
      bic_check_start <= 1'b0;
      test_start <= 1'b0;
      // Record every executed outcome
      if (rec_valid) begin
        exec_mask[test_idx] <= 1'b1;
        diagnostic_result_word[test_idx] <= ~rec_ok;
        if (!rec_ok) begin
          any_fail <= 1'b1;
        end
      end
      case (state)
        ST_IDLE: begin
          if (ctl_write && pwdata[`MST_CTL_START_BIT]) begin
            start_pend <= 1'b1;
          end
          if (start_pend) begin
            // Fresh run: node counts as failing until proven
            start_pend <= 1'b0;
            node_broken <= 1'b1;
            bus_fault_line <= 1'b1;
            selftest_done_flag <= 1'b0;
            adapter_ok <= 1'b0;
            any_fail <= 1'b0;
            diagnostic_result_word <= 17'h00000;
            exec_mask <= 17'h00000;
            port_error_reg <= 32'h00000000;
            port_data_reg <= 32'h00000000;
            single_mode <= (single_num != 5'h00);
            test_num <= (single_num != 5'h00) ? single_num : 5'h01;
            bic_check_start <= 1'b1;
            state <= ST_BIC_WAIT;
          end
        end
        ST_BIC_WAIT: begin
          // Flag sampled only after the full settle time
          if (tmr_expire) begin
            if (bic_ok_s) begin
              selftest_passed_flag <= 1'b1;
              tape_sel <= tape_s; // Strap synchroniser settled long before this
              state <= ST_ISSUE;
            end else begin
              selftest_passed_flag <= 1'b0;
              bus_drv_en <= 1'b0;
              cpu_wait <= 1'b1;
              any_fail <= 1'b1;
              diagnostic_result_word <= 17'h1FFFF;
              port_error_reg <= `MST_ERR_NOT_FUNCTIONAL;
              port_data_reg <= 32'h0001FFFF;
              selftest_done_flag <= 1'b1;
              state <= ST_HALT;
            end
          end
        end
        ST_ISSUE: begin
          // Running count while in progress
          port_data_reg <= {27'h0000000, test_num};
          if (test_num == `MST_TEST_DRIVE) begin
            state <= ST_NEXT;
          end else begin
            // Engines 1-8 sit on the main processor, 9-16 on tape
            test_id <= test_num;
            test_start <= 1'b1;
            state <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (rec_valid) begin
            if (!rec_ok && is_fatal(test_num)) begin
              // Processor or ROM broken: nothing further is trusted
              cpu_wait <= 1'b1;
              port_error_reg <= `MST_ERR_NOT_FUNCTIONAL;
              port_data_reg <= {15'h0000, diagnostic_result_word | (17'h00001 << test_idx)};
              selftest_done_flag <= 1'b1;
              state <= ST_HALT;
            end else begin
              if (rec_ok && test_num == `MST_TEST_CRIT_PATH) begin
                adapter_ok <= 1'b1;
              end
              state <= ST_NEXT;
            end
          end
        end
        ST_NEXT: begin
          if (single_mode || test_num == last_test(tape_sel)) begin
            state <= ST_DONE;
          end else begin
            test_num <= test_num + 5'h01;
            state <= ST_ISSUE;
          end
        end
        ST_DONE: begin
          selftest_done_flag <= 1'b1;
          adapter_ok <= 1'b1;
          state <= ST_IDLE;
          if (!any_fail) begin
            node_broken <= 1'b0;
            bus_fault_line <= 1'b0;
            port_error_reg <= 32'h00000000;
            port_data_reg <= 32'h00000000;
          end else begin
            // Noncritical failure: node stays flagged, rest usable
            node_broken <= 1'b1;
            bus_fault_line <= 1'b1;
            port_error_reg <= `MST_ERR_NONCRITICAL;
            port_data_reg <= {15'h0000, diagnostic_result_word};
          end
        end
        ST_HALT: begin
          // Only a reset leaves this state
          cpu_wait <= 1'b1;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Test number chosen by software; kept for the next run
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      single_num <= 5'h00;
    end else if (ctl_write && state == ST_IDLE) begin
      if (pwdata[`MST_CTL_TNUM_MSB:`MST_CTL_TNUM_LSB] <= `MST_NUM_TESTS) begin
        single_num <= pwdata[`MST_CTL_TNUM_MSB:`MST_CTL_TNUM_LSB];
      end
    end
  end

  // APB slave: answer in the first access cycle
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= apb_setup;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
      if (apb_setup) begin
        if (!selftest_passed_flag && (state == ST_HALT)) begin
          // Drivers off: every access refused
          pslverr <= 1'b1;
        end else if (!pwrite) begin
          case (paddr)
            `MST_OFS_BUS_CSR: begin
              prdata[`MST_CSR_PASSED_BIT] <= selftest_passed_flag;
              prdata[`MST_CSR_BROKE_BIT] <= node_broken;
            end
            `MST_OFS_PORT_STATUS: begin
              prdata[`MST_PS_DONE_BIT] <= selftest_done_flag;
              prdata[`MST_PS_ACC_BIT] <= adapter_ok;
              prdata[`MST_PS_RUN_BIT] <= (state != ST_IDLE) && (state != ST_HALT);
              prdata[`MST_PS_HALT_BIT] <= cpu_wait;
            end
            `MST_OFS_PORT_ERROR: begin
              prdata <= port_error_reg;
            end
            `MST_OFS_PORT_DATA: begin
              prdata <= port_data_reg;
            end
            `MST_OFS_CONTROL: begin
              prdata[`MST_CTL_TNUM_MSB:`MST_CTL_TNUM_LSB] <= single_num;
            end
            `MST_OFS_EXEC_MASK: begin
              prdata <= {15'h0000, exec_mask};
            end
            default: begin
              pslverr <= 1'b1;
            end
          endcase
        end else if (paddr != `MST_OFS_CONTROL) begin
          // Only the control word is writable
          pslverr <= 1'b1;
        end
      end
    end
  end

endmodule // mst_selftest_seq

// ===== bench/mst_selftest_monitor.sv
// Port checker for the self-test sequencer
`timescale 1ns/1ns
module mst_selftest_monitor (
  input wire clock,
  input wire rstn,
  input wire psel,
  input wire penable,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire bic_check_start,
  input wire bus_drv_en,
  input wire bus_fault_line,
  input wire test_start,
  input wire [4:0] test_id,
  input wire cpu_wait
);
  // One domain, reset quiets every check
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  // One-cycle answer to every setup
  chk_ready_pulse: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("bus answer missing or too long");
  chk_blocked_bus: assert property (!bus_drv_en && psel && !penable |=> pslverr && prdata == 32'h0)
    else $error("access served with drivers off");
  chk_dead_node: assert property (!bus_drv_en |-> !test_start && bus_fault_line)
    else $error("tests run after bus chip failure");
  // Settle wait far longer than eight cycles
  chk_wait_first: assert property (bic_check_start |=> !test_start [*8])
    else $error("test started during bus check wait");
  chk_halt_holds: assert property (cpu_wait |=> cpu_wait && !test_start)
    else $error("halt left or test issued");
  chk_pass_clean: assert property (!bus_fault_line |-> bus_drv_en && !cpu_wait)
    else $error("fault released on failing node");
  chk_test_range: assert property (test_start |-> (test_id >= 5'h01 && test_id <= 5'h10) ##1 !test_start)
    else $error("bad test number or long start");
  chk_fault_kept: assert property ($rose(cpu_wait) |-> bus_fault_line)
    else $error("fault line low at halt");
endmodule // mst_selftest_monitor
bind mst_selftest_seq mst_selftest_monitor i_mon (.clock, .rstn, .psel, .penable, .prdata, .pready,
  .pslverr, .bic_check_start, .bus_drv_en, .bus_fault_line, .test_start, .test_id, .cpu_wait);

// ===== bench/mst_engine_model.sv
// Behavioural test engines answering the sequencer
`timescale 1ns/1ns
module mst_engine_model (
  input wire clock,
  input wire rstn,
  input wire test_start,
  input wire [4:0] test_id,
  input wire [16:0] fail_mask,
  input wire slow,
  output reg test_done,
  output reg test_pass
);
  reg [3:0] cnt; // Stall cycles left
  reg [4:0] id; // Test under way
  reg busy; // Request open
  // Prompt or stalled answer; pass flag churns while idle
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      busy <= 1'b0;
      cnt <= 4'h0;
      id <= 5'h0;
      test_done <= 1'b0;
      test_pass <= 1'b0;
    end else begin
      test_done <= 1'b0;
      test_pass <= ~test_pass;
      if (test_start) begin
        busy <= 1'b1;
        id <= test_id;
        cnt <= slow ? 4'hC : 4'h0;
      end else if (busy && cnt != 4'h0) begin
        cnt <= cnt - 4'h1;
      end else if (busy) begin
        // Selected tests report failure
        busy <= 1'b0;
        test_done <= 1'b1;
        test_pass <= !fail_mask[id - 5'h1];
      end
    end
  end
endmodule // mst_engine_model

// ===== bench/tb_module_selftest_sequencer.sv
// Self-checking bench for the self-test sequencer
`timescale 1ns/1ns
`include "mst_defines.vh"
`define CHK(a,b,m) begin samples_checked++; if ((a) !== (b)) begin bad_count++; $display("MISMATCH %0t %s", $time, m); end end
module tb_module_selftest_sequencer;
  reg clock = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  reg [11:0] paddr = 12'h0; // Bus address
  reg [31:0] pwdata = 32'h0; // Write data
  reg pass_pin = 1'b1, tape = 1'b1, drive = 1'b1, slow = 1'b0; // Pins and stall mode
  reg [16:0] fmask = 17'h0; // Tests told to fail
  wire [31:0] prdata;
  wire pready, pslverr, chk_start, drv_en, fault, t_start, t_done, t_pass, cpu_wait;
  wire [4:0] t_id;
  integer bad_count = 0, samples_checked = 0, seed = 32'hF689, i, k, n, j, r;
  reg [33:0] exp_q[$]; // Notes: data care, error flag, data
  reg [33:0] ex;
  reg [31:0] rd; // Last read data
  mst_selftest_seq #(.BIC_DELAY_CYC(20), .TEST_TIMEOUT_CYC(50)) i_dut (.clock(clock), .rstn(rstn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .bic_check_start(chk_start), .selftest_passed_pin(pass_pin),
    .bus_drv_en(drv_en), .bus_fault_line(fault), .tape_fitted_pin(tape), .drive_present_pin(drive),
    .test_start(t_start), .test_id(t_id), .test_done(t_done), .test_pass(t_pass), .cpu_wait(cpu_wait));
  mst_engine_model i_eng (.clock(clock), .rstn(rstn), .test_start(t_start), .test_id(t_id),
    .fail_mask(fmask), .slow(slow), .test_done(t_done), .test_pass(t_pass));
  // Free-running clock
  initial forever #5 clock = ~clock;
  // Oldest note against each answer
  always @(posedge clock) if (pready === 1'b1) begin
    ex = exp_q.pop_front();
    `CHK(pslverr, ex[32], "error flag")
    if (ex[33]) `CHK(prdata, ex[31:0], "read data")
  end
  task wrap_up;
    begin
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
    end
  endtask
  // One transfer; held until pready seen
  task apb(input w, input [11:0] a, input [31:0] d, input c, input e, input [31:0] x);
    begin
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      exp_q.push_back({c, e, x});
      @(posedge clock);
      penable <= 1'b1;
      j = 0;
      do begin
        @(posedge clock);
        j++;
      end while (pready !== 1'b1 && j < 20);
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      if (j == 20) begin
        bad_count++;
        wrap_up;
      end
    end
  endtask
  // Reset with new pin setup
  task boot(input p, input t, input dp, input [16:0] m);
    begin
      @(posedge clock);
      r = $random(seed);
      rstn <= 1'b0;
      pass_pin <= p;
      tape <= t;
      drive <= dp;
      fmask <= m;
      slow <= r[0];
      repeat (2) @(posedge clock);
      rstn <= 1'b1;
    end
  endtask
  // Poll the done bit, bounded
  task wait_done;
    begin
      i = 0;
      rd = 32'h0;
      while (rd[0] !== 1'b1 && i < 300) begin
        apb(1'b0, `MST_OFS_PORT_STATUS, 32'h0, 1'b0, 1'b0, 32'h0);
        i++;
      end
      if (i == 300) begin
        bad_count++;
        wrap_up;
      end
    end
  endtask
  task results(input [31:0] ps, input [31:0] csr, input [31:0] pe, input [31:0] pd, input [31:0] em);
    begin
      apb(1'b0, `MST_OFS_PORT_STATUS, 32'h0, 1'b1, 1'b0, ps);
      apb(1'b0, `MST_OFS_BUS_CSR, 32'h0, 1'b1, 1'b0, csr);
      apb(1'b0, `MST_OFS_PORT_ERROR, 32'h0, 1'b1, 1'b0, pe);
      apb(1'b0, `MST_OFS_PORT_DATA, 32'h0, 1'b1, 1'b0, pd);
      apb(1'b0, `MST_OFS_EXEC_MASK, 32'h0, 1'b1, 1'b0, em);
      `CHK(fault, csr[1], "fault line")
      `CHK(cpu_wait, ps[3], "halt pin")
    end
  endtask
  initial begin
    // Full pass with tape, then without
    boot(1'b1, 1'b1, 1'b1, 17'h0);
    `CHK(fault, 1'b1, "fault at power-up")
    wait_done;
    results(32'h3, 32'h1, 32'h0, 32'h0, 32'h1FFFF);
    apb(1'b0, 12'h018, 32'h0, 1'b0, 1'b1, 32'h0);
    apb(1'b1, `MST_OFS_BUS_CSR, 32'hFFFFFFFF, 1'b0, 1'b1, 32'h0);
    // Single test, second start ignored while busy
    fmask <= 17'h10;
    apb(1'b1, `MST_OFS_CONTROL, 32'h501, 1'b0, 1'b0, 32'h0);
    apb(1'b1, `MST_OFS_CONTROL, 32'h301, 1'b0, 1'b0, 32'h0);
    // Still in the bus check wait: only the running bit is up
    apb(1'b0, `MST_OFS_PORT_STATUS, 32'h0, 1'b1, 1'b0, 32'h4);
    wait_done;
    apb(1'b0, `MST_OFS_PORT_ERROR, 32'h0, 1'b1, 1'b0, `MST_ERR_NONCRITICAL);
    apb(1'b0, `MST_OFS_EXEC_MASK, 32'h0, 1'b1, 1'b0, 32'h10);
    apb(1'b0, `MST_OFS_CONTROL, 32'h0, 1'b1, 1'b0, 32'h500);
    boot(1'b1, 1'b0, 1'b0, 17'h0);
    wait_done;
    results(32'h3, 32'h1, 32'h0, 32'h0, 32'hFF);
    // Noncritical failures run on to the end
    for (n = 0; n < 5; n++) begin
      k = (n == 0) ? 7 : (n == 1) ? 8 : 5 + {$random(seed)} % 12;
      boot(1'b1, 1'b1, n != 4, (n == 4) ? 17'h0 : 17'h1 << (k - 1));
      if (n == 4) k = 17;
      wait_done;
      results(32'h3, 32'h3, `MST_ERR_NONCRITICAL, 32'h1 << (k - 1), 32'h1FFFF);
    end
    // Critical failures halt
    boot(1'b1, 1'b1, 1'b1, 17'h1);
    wait_done;
    results(32'h9, 32'h3, `MST_ERR_NOT_FUNCTIONAL, 32'h1, 32'h1);
    boot(1'b1, 1'b1, 1'b1, 17'h8);
    wait_done;
    results(32'h9, 32'h3, `MST_ERR_NOT_FUNCTIONAL, 32'h8, 32'hF);
    // Bus chip fails its self-check
    boot(1'b0, 1'b1, 1'b1, 17'h0);
    n = 0;
    while (drv_en !== 1'b0 && n < 100) begin
      @(posedge clock);
      n++;
    end
    `CHK(drv_en, 1'b0, "drivers still on")
    `CHK(cpu_wait, 1'b1, "no halt")
    apb(1'b0, `MST_OFS_BUS_CSR, 32'h0, 1'b1, 1'b1, 32'h0);
    wrap_up;
  end
endmodule // tb_module_selftest_sequencer
